// [seq_pkg.sv]
// ---------------------------------------------------------------------------
// Shared constants and types
// ---------------------------------------------------------------------------
package seq_pkg;

	// Clock and the least low time of the reset pin.
	localparam int CLK_PERIOD_NS = 50;
	localparam int RESET_MIN_NS = 10000;
	localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	localparam int POS_W = 6;
	localparam int AMP_W = 7;

	// Register byte offsets on the bus.
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h4;
	localparam int CTRL_INHIBIT_BIT = 0;
	localparam int CTRL_RETURN_BIT = 1;
	localparam int STAT_POS_LSB = 0;
	localparam int STAT_MON_LSB = 8;
	localparam int STAT_EN_BIT = 12;
	localparam int STAT_RST_BIT = 13;

	// Current division ratio in percent, indexed by position within a quadrant.
	// Index 8 is the fully unexcited end of the quadrant.
	localparam logic [8:0][6:0] AMP_TBL = {7'h00, 7'h15, 7'h28, 7'h37, 7'h47,
		7'h53, 7'h5c, 7'h64, 7'h64};
	localparam logic [6:0] AMP_FULL = 7'h64;
	localparam logic [6:0] AMP_OFF = 7'h00;
	localparam logic [3:0] QUAD_END = 4'h8;

	// Step sizes in sixteenth-step units of the position counter.
	localparam logic [5:0] STEP_FULL = 6'h10;
	localparam logic [5:0] STEP_HALF = 6'h08;
	localparam logic [5:0] STEP_QUARTER = 6'h04;
	localparam logic [5:0] STEP_EIGHTH = 6'h02;
	localparam logic [5:0] STEP_SIXTEENTH = 6'h01;
	localparam logic [5:0] POS_ORIGIN = 6'h00;

	// Phase monitor codes {bit_a, bit_b}.
	localparam logic [1:0] MON_A = 2'h2;
	localparam logic [1:0] MON_ABAR = 2'h0;
	localparam logic [1:0] MON_B = 2'h1;
	localparam logic [1:0] MON_BBAR = 2'h3;

	typedef enum logic [2:0] {
		EXC_FULL,
		EXC_HALF,
		EXC_QUARTER,
		EXC_EIGHTH,
		EXC_SIXTEENTH
	} exc_mode_e;

	// Control pins as driven by the host.
	typedef struct packed {
		logic step_clk;
		logic clock_edge_select;
		logic step_mode_sel_hi;
		logic step_mode_sel_lo;
		logic direction_select;
		logic output_enable;
		logic reset_pin_n;
	} pins_s;

	localparam int PINS_W = $bits(pins_s);

endpackage : seq_pkg

// [sync_2ff.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Two-stage synchroniser for pin levels
// ---------------------------------------------------------------------------
module sync_2ff #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_ff;

	// The first stage feeds only the second stage, so a metastable value never fans out.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= INIT;
			q <= INIT;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end

endmodule : sync_2ff

// [microstep_phase_sequencer.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Edge select high: modes 00..11 are full, half, quarter, eighth; rising edges step.
// - Edge select low: modes 00..11 are half to sixteenth; both edges step.
// - Output enable low forces all four phase currents to zero.
// - Positions 1..7 eighths drive 100,92,83,71,55,40,21 percent; full-step drives 100.
// - Eighth uses all positions, quarter even ones, half only 0/8 and 4/8.
// - Direction low rotates clockwise, high counterclockwise.
// - Reset pin low for 10 us returns all state, phases to origin.
// - Output enable low freezes the sequencer; only reset still acts.
module microstep_phase_sequencer
	import seq_pkg::*;
#(
	parameter int RESET_CYC = RESET_MIN_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire pins_s pins,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [AMP_W-1:0] drive_a,
	output logic [AMP_W-1:0] drive_abar,
	output logic [AMP_W-1:0] drive_b,
	output logic [AMP_W-1:0] drive_bbar,
	output logic phase_monitor_bit_a,
	output logic phase_monitor_bit_b
);

	// -----------------------------------------------------------------------
	// State and helpers
	// -----------------------------------------------------------------------
	typedef struct packed {
		logic [POS_W-1:0] pos;
		logic prev_clk;
		logic [CNT_W-1:0] rst_cnt;
		logic inhibit;
		logic ret_req;
		logic [AMP_W-1:0] amp_a;
		logic [AMP_W-1:0] amp_abar;
		logic [AMP_W-1:0] amp_b;
		logic [AMP_W-1:0] amp_bbar;
		logic [1:0] mon;
		logic ack;
		logic [31:0] rdata;
	} seq_state_s;

	localparam logic [CNT_W-1:0] RST_LIMIT = CNT_W'(RESET_CYC);

	seq_state_s st_ff;
	seq_state_s nxt_st;
	pins_s pin_s;

	// Mode pins to excitation method.
	function automatic exc_mode_e decode_mode(input logic edge_sel, input logic hi,
		input logic lo);
		exc_mode_e m;
		m = EXC_FULL;
		unique case ({edge_sel, hi, lo})
			3'h4: m = EXC_FULL;
			3'h5: m = EXC_HALF;
			3'h6: m = EXC_QUARTER;
			3'h7: m = EXC_EIGHTH;
			3'h0: m = EXC_HALF;
			3'h1: m = EXC_QUARTER;
			3'h2: m = EXC_EIGHTH;
			3'h3: m = EXC_SIXTEENTH;
		endcase
		return m;
	endfunction : decode_mode

	// Position increment for one step of each method.
	function automatic logic [POS_W-1:0] step_of(input exc_mode_e m);
		logic [POS_W-1:0] s;
		s = STEP_FULL;
		unique case (m)
			EXC_FULL: s = STEP_FULL;
			EXC_HALF: s = STEP_HALF;
			EXC_QUARTER: s = STEP_QUARTER;
			EXC_EIGHTH: s = STEP_EIGHTH;
			EXC_SIXTEENTH: s = STEP_SIXTEENTH;
		endcase
		return s;
	endfunction : step_of

	// -----------------------------------------------------------------------
	// Pin synchronisation
	// -----------------------------------------------------------------------
	// All pins come from the host's domain; the reset pin idles high.
	sync_2ff #(
		.W(PINS_W),
		.INIT(PINS_W'(1))
	) u_pin_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.d(pins),
		.q(pin_s)
	);

	// -----------------------------------------------------------------------
	// Next-state logic
	// -----------------------------------------------------------------------
	// The quadrant picks which phase pair carries current; the position inside
	// the quadrant picks the ratio. Sixteenth positions share the ratio of the
	// eighth position below them, as no finer ratios exist.
	always_comb begin
		exc_mode_e mode;
		logic [POS_W-1:0] step;
		logic rise;
		logic fall;
		logic advance;
		logic hit;
		logic do_write;
		logic [AMP_W-1:0] prim;
		logic [AMP_W-1:0] sec;
		logic [3:0] idx;
		nxt_st = st_ff;
		mode = decode_mode(pin_s.clock_edge_select, pin_s.step_mode_sel_hi,
			pin_s.step_mode_sel_lo);
		step = step_of(mode);
		rise = pin_s.step_clk && !st_ff.prev_clk;
		fall = !pin_s.step_clk && st_ff.prev_clk;
		hit = 1'b0;
		advance = 1'b0;
		do_write = 1'b0;
		idx = '0;
		prim = AMP_OFF;
		sec = AMP_OFF;

		// Previous level follows always, so re-enabling never sees a stale edge.
		nxt_st.prev_clk = pin_s.step_clk;

		// A step is taken only while enabled and not inhibited by software.
		advance = pin_s.output_enable && !st_ff.inhibit &&
			(rise || (fall && !pin_s.clock_edge_select));
		if (advance) begin
			if (pin_s.direction_select) begin
				nxt_st.pos = st_ff.pos - step;
			end else begin
				nxt_st.pos = st_ff.pos + step;
			end
		end

		// Software return to origin; the request bit clears itself.
		if (st_ff.ret_req && pin_s.output_enable) begin
			nxt_st.pos = POS_ORIGIN;
			nxt_st.ret_req = 1'b0;
		end

		// Bus slave: one wait state, ack dropped the cycle after it is given.
		do_write = wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack && wb_sel_i[0];
		nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
		nxt_st.rdata = '0;
		if (wb_cyc_i && wb_stb_i && !st_ff.ack && !wb_we_i) begin
			unique case (wb_adr_i)
				REG_STATUS: begin
					nxt_st.rdata[STAT_POS_LSB +: POS_W] = st_ff.pos;
					nxt_st.rdata[STAT_MON_LSB +: 2] = st_ff.mon;
					nxt_st.rdata[STAT_EN_BIT] = pin_s.output_enable;
					nxt_st.rdata[STAT_RST_BIT] = !pin_s.reset_pin_n;
				end
				REG_CTRL: begin
					nxt_st.rdata[CTRL_INHIBIT_BIT] = st_ff.inhibit;
					nxt_st.rdata[CTRL_RETURN_BIT] = st_ff.ret_req;
				end
				default: nxt_st.rdata = '0;
			endcase
		end
		if (do_write && wb_adr_i == REG_CTRL) begin
			nxt_st.inhibit = wb_dat_i[CTRL_INHIBIT_BIT];
			nxt_st.ret_req = wb_dat_i[CTRL_RETURN_BIT];
		end

		// Reset pin must stay low long enough to count as a reset.
		if (!pin_s.reset_pin_n) begin
			if (st_ff.rst_cnt != RST_LIMIT) begin
				nxt_st.rst_cnt = st_ff.rst_cnt + CNT_W'(1);
			end else begin
				hit = 1'b1;
			end
		end else begin
			nxt_st.rst_cnt = '0;
		end
		if (hit) begin
			nxt_st.pos = POS_ORIGIN;
			nxt_st.inhibit = 1'b0;
			nxt_st.ret_req = 1'b0;
		end

		// Phase currents from the next position.
		idx = {1'b0, nxt_st.pos[3:1]};
		prim = AMP_TBL[idx];
		sec = AMP_TBL[QUAD_END - idx];
		if (mode == EXC_FULL) begin
			prim = AMP_FULL;
			sec = AMP_FULL;
		end
		nxt_st.amp_a = AMP_OFF;
		nxt_st.amp_abar = AMP_OFF;
		nxt_st.amp_b = AMP_OFF;
		nxt_st.amp_bbar = AMP_OFF;
		unique case (nxt_st.pos[5:4])
			2'h0: begin
				nxt_st.amp_a = prim;
				nxt_st.amp_b = sec;
				nxt_st.mon = MON_A;
			end
			2'h1: begin
				nxt_st.amp_b = prim;
				nxt_st.amp_abar = sec;
				nxt_st.mon = MON_B;
			end
			2'h2: begin
				nxt_st.amp_abar = prim;
				nxt_st.amp_bbar = sec;
				nxt_st.mon = MON_ABAR;
			end
			2'h3: begin
				nxt_st.amp_bbar = prim;
				nxt_st.amp_a = sec;
				nxt_st.mon = MON_BBAR;
			end
		endcase

		// Disabled outputs carry no current whatever the position.
		if (!pin_s.output_enable) begin
			nxt_st.amp_a = AMP_OFF;
			nxt_st.amp_abar = AMP_OFF;
			nxt_st.amp_b = AMP_OFF;
			nxt_st.amp_bbar = AMP_OFF;
		end
	end

	// -----------------------------------------------------------------------
	// State register and outputs
	// -----------------------------------------------------------------------
	// Power-on reset places the phases at origin; outputs start cut off.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
			st_ff.mon <= MON_A;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign drive_a = st_ff.amp_a;
	assign drive_abar = st_ff.amp_abar;
	assign drive_b = st_ff.amp_b;
	assign drive_bbar = st_ff.amp_bbar;
	assign phase_monitor_bit_a = st_ff.mon[1];
	assign phase_monitor_bit_b = st_ff.mon[0];
	assign wb_ack_o = st_ff.ack;
	assign wb_dat_o = st_ff.rdata;

endmodule : microstep_phase_sequencer

// [host_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host driving the step clock and the control pins
// ---------------------------------------------------------------
module host_model
	import seq_pkg::*;
(
	input wire logic ref_clk,
	output pins_s pins
);
	// Idle host: rising edges, clockwise, enabled, reset pin released.
	initial begin
		pins = 7'h23;
	end
	// Each level lasts four clocks so the two sync flops never miss one.
	task automatic pulse(input logic [3:0] n);
		repeat (n) begin
			repeat (4) @(posedge ref_clk);
			pins.step_clk <= ~pins.step_clk;
		end
	endtask : pulse
	// Mode changes at least four clocks ahead of the next step edge.
	task automatic mode(input logic [3:0] m);
		@(posedge ref_clk);
		{pins.clock_edge_select, pins.step_mode_sel_hi, pins.step_mode_sel_lo,
			pins.direction_select} <= m;
	endtask : mode
	task automatic level(input logic oe, input logic rn);
		@(posedge ref_clk);
		pins.output_enable <= oe;
		pins.reset_pin_n <= rn;
	endtask : level
endmodule : host_model

// [msq_assertions.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module msq_checker
	import seq_pkg::*;
#(
	parameter int RESET_CYC = RESET_MIN_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire pins_s pins,
	input wire logic [AMP_W-1:0] drive_a,
	input wire logic [AMP_W-1:0] drive_abar,
	input wire logic [AMP_W-1:0] drive_b,
	input wire logic [AMP_W-1:0] drive_bbar,
	input wire logic phase_monitor_bit_a,
	input wire logic phase_monitor_bit_b
);
	logic [1:0] mon;
	logic [7:0] low_cnt_ff;
	assign mon = {phase_monitor_bit_a, phase_monitor_bit_b};
	// Counts low samples of the reset pin; saturates so it never wraps.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			low_cnt_ff <= 8'h00;
		end else begin
			low_cnt_ff <= pins.reset_pin_n ? 8'h00 : low_cnt_ff + {7'h00, ~&low_cnt_ff};
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	property p_cut;
		(!pins.output_enable) [*3] |=> {drive_a, drive_abar, drive_b, drive_bbar} == 28'h0;
	endproperty
	a_cut: assert property (p_cut) else $error("current on while disabled");
	property p_hold;
		(!pins.output_enable && pins.reset_pin_n) [*4] |=> $stable(mon);
	endproperty
	a_hold: assert property (p_hold) else $error("phase moved while disabled");
	property p_rise;
		(pins.clock_edge_select && !$rose(pins.step_clk) && pins.reset_pin_n) [*4]
			|=> $stable(mon);
	endproperty
	a_rise: assert property (p_rise) else $error("step without rising edge");
	property p_tbl;
		drive_a inside {7'h00, 7'h15, 7'h28, 7'h37, 7'h47, 7'h53, 7'h5c, 7'h64};
	endproperty
	a_tbl: assert property (p_tbl) else $error("current ratio off table");
	property p_mon_a;
		mon == MON_A |-> drive_abar == AMP_OFF && drive_bbar == AMP_OFF;
	endproperty
	a_mon_a: assert property (p_mon_a) else $error("monitor A mismatch");
	property p_mon_b;
		mon == MON_B |-> drive_a == AMP_OFF && drive_bbar == AMP_OFF;
	endproperty
	a_mon_b: assert property (p_mon_b) else $error("monitor B mismatch");
	property p_origin;
		int'(low_cnt_ff) >= RESET_CYC + 4 |-> mon == MON_A && drive_abar == AMP_OFF;
	endproperty
	a_origin: assert property (p_origin) else $error("reset pin left phase off origin");
	property p_dir;
		$past(mon) == MON_A && mon != MON_A
			|-> mon == ($past(pins.direction_select, 3) ? MON_BBAR : MON_B);
	endproperty
	a_dir: assert property (p_dir) else $error("wrong rotation sense");
endmodule : msq_checker
bind microstep_phase_sequencer msq_checker #(.RESET_CYC(RESET_CYC)) msq_checker_inst (
	.ref_clk, .nrst, .pins, .drive_a, .drive_abar, .drive_b, .drive_bbar,
	.phase_monitor_bit_a, .phase_monitor_bit_b
);

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import seq_pkg::*;
	// ---------------------------------------------------------------
	// Rows: mode, step edges, then monitor and a, abar, b, bbar
	// ---------------------------------------------------------------
	localparam logic [37:0] ROWS [13] = '{
		{4'h8, 4'h1, 2'h1, 7'h00, 7'h64, 7'h64, 7'h00}, {4'h8, 4'h1, 2'h1, 7'h00, 7'h64, 7'h64, 7'h00},
		{4'ha, 4'h1, 2'h1, 7'h00, 7'h47, 7'h47, 7'h00}, {4'h2, 4'h1, 2'h1, 7'h00, 7'h5c, 7'h28, 7'h00},
		{4'h6, 4'h2, 2'h1, 7'h00, 7'h64, 7'h15, 7'h00}, {4'h7, 4'h2, 2'h1, 7'h00, 7'h5c, 7'h28, 7'h00},
		{4'hf, 4'h2, 2'h1, 7'h00, 7'h53, 7'h37, 7'h00}, {4'h4, 4'h3, 2'h0, 7'h00, 7'h64, 7'h00, 7'h00},
		{4'h0, 4'h1, 2'h0, 7'h00, 7'h47, 7'h00, 7'h47}, {4'hc, 4'h1, 2'h0, 7'h00, 7'h28, 7'h00, 7'h5c},
		{4'hb, 4'h2, 2'h0, 7'h00, 7'h5c, 7'h00, 7'h28}, {4'h8, 4'h2, 2'h3, 7'h64, 7'h00, 7'h00, 7'h64},
		{4'h8, 4'h2, 2'h2, 7'h64, 7'h00, 7'h64, 7'h00}};
	localparam logic [31:0] E12 = {2'h0, 2'h2, 7'h28, 7'h00, 7'h5c, 7'h00};
	logic ref_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, phase_monitor_bit_a, phase_monitor_bit_b;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [AMP_W-1:0] drive_a, drive_abar, drive_b, drive_bbar;
	pins_s pins;
	int bad_count, cmp_count, cyc;
	host_model host_model_inst (.ref_clk, .pins);
	microstep_phase_sequencer #(.RESET_CYC(4)) microstep_phase_sequencer_inst (.ref_clk, .nrst,
		.pins, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .drive_a, .drive_abar, .drive_b, .drive_bbar, .phase_monitor_bit_a,
		.phase_monitor_bit_b);
	function automatic logic [31:0] obs();
		return {2'h0, phase_monitor_bit_a, phase_monitor_bit_b, drive_a, drive_abar, drive_b,
			drive_bbar};
	endfunction : obs
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Steps land three clocks after the pin edge; six leaves margin.
	task automatic step_wait(input logic [3:0] n);
		host_model_inst.pulse(n);
		repeat (6) @(posedge ref_clk);
	endtask : step_wait
	task automatic pulse_rst(input int k);
		host_model_inst.level(1'b1, 1'b0);
		repeat (k) @(posedge ref_clk);
		host_model_inst.level(1'b1, 1'b1);
		repeat (6) @(posedge ref_clk);
	endtask : pulse_rst
	// Classic single cycle; entered just after a rising edge.
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'h1;
		wb_dat_i <= d;
		// Only the bench timeout ends a wait for an answer that never comes.
		do begin
			@(posedge ref_clk);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask : wb
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// A hang counts as a mismatch and ends the run.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		logic [37:0] r;
		nrst = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0;
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		pulse_rst(12);
		for (int i = 0; i < 13; i++) begin
			r = ROWS[i];
			host_model_inst.mode(r[37:34]);
			step_wait(r[33:30]);
			chk(obs(), {2'h0, r[29:0]});
		end
		$display("test mode rows done");
		host_model_inst.mode(4'ha);
		step_wait(4'h2);
		chk(obs(), E12);
		host_model_inst.level(1'b0, 1'b1);
		step_wait(4'h2);
		chk(obs(), {4'h2, 28'h0});
		host_model_inst.level(1'b1, 1'b1);
		step_wait(4'h0);
		chk(obs(), E12);
		wb(1'b0, REG_STATUS, 32'h0, q);
		chk(q, 32'h0000120c);
		wb(1'b1, REG_CTRL, 32'h1, q);
		step_wait(4'h2);
		chk(obs(), E12);
		wb(1'b0, 4'h8, 32'h0, q);
		chk(q, 32'h0);
		wb(1'b1, REG_CTRL, 32'h0, q);
		pulse_rst(2);
		chk(obs(), E12);
		// Return to origin through the control register clears itself once taken.
		wb(1'b1, REG_CTRL, 32'h2, q);
		step_wait(4'h0);
		chk(obs(), {4'h2, 7'h64, 21'h0});
		wb(1'b0, REG_CTRL, 32'h0, q);
		chk(q, 32'h0);
		step_wait(4'h2);
		chk(obs(), {4'h2, 7'h47, 7'h00, 7'h47, 7'h00});
		pulse_rst(12);
		chk(obs(), {4'h2, 7'h64, 21'h0});
		$display("test hand cases done");
		stop_test();
	end
endmodule : tb_top
